// *** sim/cec_analog_model.sv ***
// Purpose: far-side model of the compare inputs and package bonding
// Assumes: one test level per instance, placed on its selected channel
// Notes: unselected channels carry the inverse level so a wrong mux shows
module cec_analog_model #(
	parameter logic [19:0] BONDED = 20'h77777
) (
	input wire logic [4:0] level_i,
	input wire logic [9:0] chan_i,
	output logic [19:0] raw_o,
	output logic [19:0] bonded_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Unbonded channels still show a live level; grounding them is the block's job
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			for (int c = 0; c < 4; c++) begin
				raw_o[i*4+c] = (chan_i[i*2+:2] == 2'(c)) ? level_i[i] : ~level_i[i];
			end
		end
	end
	assign bonded_o = BONDED;
endmodule

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the comparator event control block
// Assumes: channel 3 of every instance is unbonded in the model
// Notes: input levels need about five cycles to reach the result bit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [4:0] level = 5'h00;
	logic [19:0] raw;
	logic [19:0] bonded;
	logic [15:0] rdata;
	logic [4:0] pin;
	logic [4:0] cen;
	logic [4:0] aen;
	logic [4:0] rsel;
	logic [9:0] csel;
	logic [4:0] trig;
	logic irq;
	int n_errors = 0;
	int num_checks = 0;
	always #2.5 core_clk = ~core_clk;
	cec_analog_model cec_analog_model_inst (.level_i(level), .chan_i(csel), .raw_o(raw), .bonded_o(bonded));
	cec_top cec_top_inst (.core_clk_i(core_clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .cmp_raw_i(raw), .chan_bonded_i(bonded), .rdata_o(rdata), .cmp_out_pin_o(pin),
		.cmp_enable_o(cen), .amp_enable_o(aen), .ref_select_o(rsel), .chan_select_o(csel), .trigger_o(trig),
		.irq_o(irq));
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task settle;
		repeat (10) @(posedge core_clk);
		#1;
	endtask
	task count_trig(input int i, inout int seen);
		repeat (20) begin
			@(posedge core_clk);
			#1 if (trig[i] === 1'b1) seen++;
		end
	endtask
	task ev_test(input int i, input logic [1:0] code, input logic idle);
		int seen;
		seen = 0;
		@(posedge core_clk);
		level[i] <= idle;
		wr_reg(4'(i), {8'h80, code, 6'h00});
		settle();
		rd_chk(4'(i), {7'h40, idle, code, 6'h00});
		rd_chk(cec_pkg::OFF_IRQ_STAT, 16'h0000);
		wr_reg(cec_pkg::OFF_IRQ_MASK, 16'(5'h01 << i));
		@(posedge core_clk);
		level[i] <= ~idle;
		count_trig(i, seen);
		chk(16'(seen), 16'h0001);
		chk(16'(irq), 16'h0001);
		rd_chk(cec_pkg::OFF_IRQ_STAT, 16'(5'h01 << i));
		@(posedge core_clk);
		level[i] <= idle;
		settle();
		@(posedge core_clk);
		level[i] <= ~idle;
		count_trig(i, seen);
		chk(16'(seen), 16'h0001);
		chk(16'(irq), 16'h0000);
		rd_chk(4'(i), {7'h41, ~idle, code, 6'h00});
		// Clearing the flag must re-arm the instance
		wr_reg(4'(i), {8'h80, code, 6'h00});
		@(posedge core_clk);
		level[i] <= idle;
		settle();
		@(posedge core_clk);
		level[i] <= ~idle;
		count_trig(i, seen);
		chk(16'(seen), 16'h0002);
		rd_chk(cec_pkg::OFF_IRQ_STAT, 16'(5'h01 << i));
		wr_reg(4'(i), 16'h0000);
		$display("event test %0d done", i);
	endtask
	task reg_test;
		rd_chk(cec_pkg::OFF_CTRL0, 16'h0000);
		rd_chk(cec_pkg::OFF_IRQ_MASK, 16'h0000);
		rd_chk(4'hf, 16'h0000);
		wr_reg(4'h0, 16'h7cff);
		wr_reg(4'h3, 16'h7cff);
		rd_chk(4'h0, 16'h64d3);
		rd_chk(4'h3, 16'h60d3);
		chk(16'(rsel), 16'h0009);
		wr_reg(4'h0, 16'h0000);
		wr_reg(4'h3, 16'h8400);
		wr_reg(4'h1, 16'h8400);
		settle();
		chk(16'(aen), 16'h0002);
		chk(16'(cen[1]), 16'h0001);
		rd_chk(4'h3, 16'h8000);
		$display("register test done");
	endtask
	task out_test;
		wr_reg(4'h1, 16'he000);
		level[1] <= 1'b1;
		settle();
		chk(16'(pin[1]), 16'h0000);
		rd_chk(4'h1, 16'he000);
		@(posedge core_clk);
		level[1] <= 1'b0;
		settle();
		chk(16'(pin[1]), 16'h0001);
		rd_chk(4'h1, 16'he100);
		wr_reg(4'h1, 16'ha000);
		settle();
		chk(16'(pin[1]), 16'h0000);
		wr_reg(4'h2, 16'h8003);
		level[2] <= 1'b1;
		settle();
		rd_chk(4'h2, 16'h8003);
		wr_reg(4'h2, 16'h8000);
		settle();
		rd_chk(4'h2, 16'h8100);
		$display("output test done");
	endtask
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		reg_test();
		out_test();
		ev_test(0, cec_pkg::EDGE_RISE, 1'b0);
		ev_test(4, cec_pkg::EDGE_FALL, 1'b1);
		stop_test();
	end
endmodule

// *** verilog/cec_pkg.sv ***
// Purpose: constants for the comparator event control block
// Assumes: 16-bit register port, one clock domain
// Notes: register offsets are word indices on the plain register port
package cec_pkg;
	localparam int NUM_CMP = 5;
	localparam int AW = 4;
	// Register offsets
	localparam logic [3:0] OFF_CTRL0 = 4'h0;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFF_IRQ_MASK = 4'h9;
	// Control register field positions
	localparam int BIT_ENABLE = 15;
	localparam int BIT_PIN_OE = 14;
	localparam int BIT_INVERT = 13;
	localparam int BIT_AMP_EN = 10;
	localparam int BIT_EVENT = 9;
	localparam int BIT_RESULT = 8;
	localparam int BIT_EDGE_HI = 7;
	localparam int BIT_EDGE_LO = 6;
	localparam int BIT_REF_SEL = 4;
	localparam int BIT_CH_HI = 1;
	localparam int BIT_CH_LO = 0;
	// Writable bits; result is read-only, reserved bits read zero
	localparam logic [15:0] CTRL_WMASK = 16'he6d3;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// Instances 1,2,3 and 5 have an amplifier; bit n is instance n+1
	localparam logic [4:0] AMP_PRESENT = 5'h17;
	// Edge select codes
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_RISE = 2'h1;
endpackage

// *** verilog/cec_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter for compare inputs
// Assumes: inputs are asynchronous analog comparator outputs
// Notes: stage one feeds stage two only
module cec_sync (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [4:0] raw_i,
	cec_sync_if.src sync
);
	logic [4:0] s1_r, s2_r, s3_r, lvl_r;
	logic [4:0] lvl_nxt;

	always_comb begin
		lvl_nxt = lvl_r;
		for (int i = 0; i < 5; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				lvl_nxt[i] = s2_r[i];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
			s3_r <= 5'h00;
			lvl_r <= 5'h00;
		end else begin
			s1_r <= raw_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign sync.level = lvl_r;
endmodule

// *** verilog/cec_sync_if.sv ***
// Purpose: carries synchronised, filtered compare levels from the synchroniser to the core
// Assumes: one bit per instance
// Notes: none
interface cec_sync_if;
	logic [4:0] level;
	modport src(output level);
	modport dst(input level);
endinterface

// *** verilog/cec_top.sv ***
// Purpose: control, edge event and output logic for five comparator instances
// Assumes: analog compare results arrive on cmp_raw_i, one per input selection
// Notes: register port has read data one cycle after the read strobe
//
// Summary of operation
// - Five independent instances, each with control register, enable, polarity, event logic.
// - Only instances 1, 2, 3 and 5 offer the amplifier output.
// - Amplifier enable turns on only the amplifier; comparator keeps working.
// - Selected edge sets the event flag; flag blocks triggers and interrupts.
// - Edge code 10 is high-to-low, 01 is low-to-high.
// - An input channel not bonded out reads as ground.
module cec_top (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [19:0] cmp_raw_i,
	input wire logic [19:0] chan_bonded_i,
	output logic [15:0] rdata_o,
	output logic [4:0] cmp_out_pin_o,
	output logic [4:0] cmp_enable_o,
	output logic [4:0] amp_enable_o,
	output logic [4:0] ref_select_o,
	output logic [9:0] chan_select_o,
	output logic [4:0] trigger_o,
	output logic irq_o
);
	// ---------------------------------------------------------------
	// Input selection and synchronisation
	// ---------------------------------------------------------------
	cec_sync_if sif();
	logic [4:0] sel_raw;
	logic [15:0] ctrl_r [5];
	logic [15:0] ctrl_nxt [5];

	generate
		for (genvar g = 0; g < 5; g++) begin : g_sel
			logic [1:0] ch;
			assign ch = ctrl_r[g][cec_pkg::BIT_CH_HI:cec_pkg::BIT_CH_LO];
			// Unbonded channels are forced to ground
			assign sel_raw[g] = cmp_raw_i[g*4 + int'(ch)] & chan_bonded_i[g*4 + int'(ch)];
		end
	endgenerate

	cec_sync u_sync (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.raw_i(sel_raw),
		.sync(sif.src)
	);

	// ---------------------------------------------------------------
	// Per-instance state
	// ---------------------------------------------------------------
	logic [4:0] res_r, res_nxt;
	logic [4:0] ev_set;
	logic [4:0] pin_nxt, en_nxt, amp_nxt, ref_nxt, trig_nxt;
	logic [9:0] ch_nxt;
	logic [4:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [15:0] rdata_nxt;
	logic irq_nxt;
	logic [4:0] pin_r, en_r, amp_r, ref_r, trig_r;
	logic [9:0] ch_r;
	logic irq_r;

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			logic on;
			logic cur;
			logic [1:0] edge_sel;
			on = ctrl_r[i][cec_pkg::BIT_ENABLE];
			edge_sel = ctrl_r[i][cec_pkg::BIT_EDGE_HI:cec_pkg::BIT_EDGE_LO];
			// Comparator stays live regardless of amplifier enable
			cur = on & (sif.level[i] ^ ctrl_r[i][cec_pkg::BIT_INVERT]);
			res_nxt[i] = cur;
			ev_set[i] = 1'b0;
			// Flag already set blocks any further event
			if (on && !ctrl_r[i][cec_pkg::BIT_EVENT]) begin
				if (edge_sel == cec_pkg::EDGE_FALL && res_r[i] && !cur) begin
					ev_set[i] = 1'b1;
				end else if (edge_sel == cec_pkg::EDGE_RISE && !res_r[i] && cur) begin
					ev_set[i] = 1'b1;
				end
			end
			trig_nxt[i] = ev_set[i];
			pin_nxt[i] = cur & ctrl_r[i][cec_pkg::BIT_PIN_OE];
			en_nxt[i] = on;
			// Amplifier only exists on instances with one
			amp_nxt[i] = cec_pkg::AMP_PRESENT[i] & ctrl_r[i][cec_pkg::BIT_AMP_EN];
			ref_nxt[i] = ctrl_r[i][cec_pkg::BIT_REF_SEL];
			ch_nxt[i*2 +: 2] = ctrl_r[i][cec_pkg::BIT_CH_HI:cec_pkg::BIT_CH_LO];
		end
	end

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			logic [15:0] wm;
			wm = cec_pkg::CTRL_WMASK;
			if (!cec_pkg::AMP_PRESENT[i]) begin
				wm[cec_pkg::BIT_AMP_EN] = 1'b0;
			end
			ctrl_nxt[i] = ctrl_r[i];
			if (wr_i && addr_i == (cec_pkg::OFF_CTRL0 + 4'(i))) begin
				ctrl_nxt[i] = (ctrl_r[i] & ~wm) | (wdata_i & wm);
			end
			ctrl_nxt[i][cec_pkg::BIT_RESULT] = res_nxt[i];
			// Hardware set wins over a software clear in the same cycle
			if (ev_set[i]) begin
				ctrl_nxt[i][cec_pkg::BIT_EVENT] = 1'b1;
			end
		end
		stat_nxt = stat_r;
		mask_nxt = mask_r;
		rdata_nxt = 16'h0000;
		if (rd_i) begin
			if (addr_i < cec_pkg::OFF_CTRL0 + 4'h5) begin
				rdata_nxt = ctrl_r[addr_i[2:0]];
			end else if (addr_i == cec_pkg::OFF_IRQ_STAT) begin
				rdata_nxt = {11'h000, stat_r};
				stat_nxt = 5'h00;
			end else if (addr_i == cec_pkg::OFF_IRQ_MASK) begin
				rdata_nxt = {11'h000, mask_r};
			end
		end
		if (wr_i && addr_i == cec_pkg::OFF_IRQ_MASK) begin
			mask_nxt = wdata_i[4:0];
		end
		stat_nxt = stat_nxt | ev_set;
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 5; i++) begin
				ctrl_r[i] <= cec_pkg::CTRL_RESET;
			end
			res_r <= 5'h00;
			stat_r <= 5'h00;
			mask_r <= 5'h00;
			rdata_o <= 16'h0000;
			irq_r <= 1'b0;
			pin_r <= 5'h00;
			en_r <= 5'h00;
			amp_r <= 5'h00;
			ref_r <= 5'h00;
			ch_r <= 10'h000;
			trig_r <= 5'h00;
		end else begin
			for (int i = 0; i < 5; i++) begin
				ctrl_r[i] <= ctrl_nxt[i];
			end
			res_r <= res_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rdata_o <= rdata_nxt;
			irq_r <= irq_nxt;
			pin_r <= pin_nxt;
			en_r <= en_nxt;
			amp_r <= amp_nxt;
			ref_r <= ref_nxt;
			ch_r <= ch_nxt;
			trig_r <= trig_nxt;
		end
	end

	assign cmp_out_pin_o = pin_r;
	assign cmp_enable_o = en_r;
	assign amp_enable_o = amp_r;
	assign ref_select_o = ref_r;
	assign chan_select_o = ch_r;
	assign trigger_o = trig_r;
	assign irq_o = irq_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_event_blocks;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ctrl_r[0][cec_pkg::BIT_EVENT] |=> !trigger_o[0];
	endproperty
	a_event_blocks: assert property (p_event_blocks) else $error("event while flag set");

	property p_trig_sets_flag;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ev_set[4] |=> ctrl_r[4][cec_pkg::BIT_EVENT] && trigger_o[4] && stat_r[4];
	endproperty
	a_trig_sets_flag: assert property (p_trig_sets_flag) else $error("flag not set by event");

	property p_trigger_single;
		@(posedge core_clk_i) disable iff (!nrst_i)
		trigger_o[0] |=> !trigger_o[0];
	endproperty
	a_trigger_single: assert property (p_trigger_single) else $error("trigger longer than one cycle");

	// Flag must hold until software writes it back to zero
	property p_event_sticky;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ctrl_r[4][cec_pkg::BIT_EVENT] && !(wr_i && addr_i == cec_pkg::OFF_CTRL0 + 4'h4)
			|=> ctrl_r[4][cec_pkg::BIT_EVENT];
	endproperty
	a_event_sticky: assert property (p_event_sticky) else $error("event flag dropped by itself");

	property p_flag_blocks_irq;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ctrl_r[4][cec_pkg::BIT_EVENT] && !stat_r[4] |=> !stat_r[4];
	endproperty
	a_flag_blocks_irq: assert property (p_flag_blocks_irq) else $error("interrupt while flag set");

	sequence s_fall;
		res_r[4] ##1 !res_r[4];
	endsequence
	sequence s_rise;
		!res_r[0] ##1 res_r[0];
	endsequence
	property p_fall_edge;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ev_set[4] && ctrl_r[4][cec_pkg::BIT_EDGE_HI:cec_pkg::BIT_EDGE_LO] == cec_pkg::EDGE_FALL |-> s_fall;
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("wrong fall event");

	property p_rise_edge;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ev_set[0] && ctrl_r[0][cec_pkg::BIT_EDGE_HI:cec_pkg::BIT_EDGE_LO] == cec_pkg::EDGE_RISE |-> s_rise;
	endproperty
	a_rise_edge: assert property (p_rise_edge) else $error("wrong rise event");

	// ---------------------------------------------------------------
	// Output checks
	// ---------------------------------------------------------------
	property p_no_amp4;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!amp_enable_o[3];
	endproperty
	a_no_amp4: assert property (p_no_amp4) else $error("amplifier on instance 4");

	property p_amp_blocked;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!ctrl_r[3][cec_pkg::BIT_AMP_EN];
	endproperty
	a_amp_blocked: assert property (p_amp_blocked) else $error("amplifier bit stored on instance 4");

	property p_amp_keeps_cmp;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ctrl_r[1][cec_pkg::BIT_AMP_EN] && ctrl_r[1][cec_pkg::BIT_ENABLE] |=> cmp_enable_o[1] && amp_enable_o[1];
	endproperty
	a_amp_keeps_cmp: assert property (p_amp_keeps_cmp) else $error("comparator off with amplifier");

	property p_pin_gate;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!ctrl_r[1][cec_pkg::BIT_PIN_OE] |=> !cmp_out_pin_o[1];
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled");

	property p_pin_follows;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ctrl_r[1][cec_pkg::BIT_PIN_OE] |=> cmp_out_pin_o[1] == ctrl_r[1][cec_pkg::BIT_RESULT];
	endproperty
	a_pin_follows: assert property (p_pin_follows) else $error("pin differs from result");

	property p_result_pol;
		@(posedge core_clk_i) disable iff (!nrst_i)
		ctrl_r[1][cec_pkg::BIT_ENABLE]
			|=> ctrl_r[1][cec_pkg::BIT_RESULT] == ($past(sif.level[1]) ^ $past(ctrl_r[1][cec_pkg::BIT_INVERT]));
	endproperty
	a_result_pol: assert property (p_result_pol) else $error("result polarity wrong");

	// Disabled instances must not leak a stale result to software
	property p_result_off;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!ctrl_r[2][cec_pkg::BIT_ENABLE] |=> !ctrl_r[2][cec_pkg::BIT_RESULT];
	endproperty
	a_result_off: assert property (p_result_off) else $error("result set while disabled");

	// ---------------------------------------------------------------
	// Register port checks
	// ---------------------------------------------------------------
	property p_irq;
		@(posedge core_clk_i) disable iff (!nrst_i)
		irq_o == |(stat_r & mask_r);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	property p_stat_clear;
		@(posedge core_clk_i) disable iff (!nrst_i)
		rd_i && addr_i == cec_pkg::OFF_IRQ_STAT && ev_set == 5'h00 |=> stat_r == 5'h00;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

	property p_mask_write;
		@(posedge core_clk_i) disable iff (!nrst_i)
		wr_i && addr_i == cec_pkg::OFF_IRQ_MASK |=> mask_r == $past(wdata_i[4:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	// Read data is only valid for one cycle, zero elsewhere
	property p_rdata_idle;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!rd_i |=> rdata_o == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule
